/* File: rtl/smcc_defines.svh */
// command field codes, field positions and widths for the management codec
`ifndef SMCC_DEFINES_SVH
`define SMCC_DEFINES_SVH

// ----------------------------------------------------------------
// field widths and positions
// ----------------------------------------------------------------
`define SMCC_CMD_W       12
`define SMCC_GRP_MSB     11
`define SMCC_GRP_LSB     4
`define SMCC_TOP_MSB     11
`define SMCC_TOP_LSB     7
`define SMCC_LOW_MSB     3
`define SMCC_ACT_MSB     3
`define SMCC_ACT_LSB     1
`define SMCC_WIRE_BIT    0
`define SMCC_A20_BIT     1
`define SMCC_HALT_BIT    3
`define SMCC_LINE_MSB    3
`define SMCC_LINE_LSB    2
`define SMCC_LVL_BIT     1
`define SMCC_CORE_MSB    6
`define SMCC_CORE_LSB    3
`define SMCC_STATE_MSB   2
`define SMCC_PAY_W       9
`define SMCC_KIND_W      5
`define SMCC_LINES       4
`define SMCC_CNT_W       4
`define SMCC_CNT_MAX     4'hf
`define SMCC_CNT_ZERO    4'h0
`define SMCC_CNT_ONE     4'h1

// ----------------------------------------------------------------
// eight-bit code groups, bits 11:4
// ----------------------------------------------------------------
`define SMCC_GRP_RSVD     8'h00
`define SMCC_GRP_LEG_IN   8'h01
`define SMCC_GRP_LEG_OUT  8'h02
`define SMCC_GRP_CLOCK_STOP_REQUEST   8'h03
`define SMCC_GRP_CATASTROPHIC_ERROR_CYCLE 8'h04
`define SMCC_GRP_HALT     8'h05
`define SMCC_GRP_STOPGNT  8'h06
`define SMCC_GRP_VIDFID   8'h07
`define SMCC_GRP_CACHE_WRITEBACK_INVALIDATE   8'h08
`define SMCC_GRP_CACHE_INVALIDATE_ONLY     8'h09
`define SMCC_GRP_MGMT_MODE_ACKNOWLEDGE   8'h0a
`define SMCC_GRP_LEGACY_IRQ_LINE_MESSAGE     8'h0b
`define SMCC_GRP_THROTTLE 8'h0c
`define SMCC_GRP_THERMAL  8'h0d
`define SMCC_GRP_VW_LO    8'h0e
`define SMCC_GRP_VW_HI    8'h0f

// ----------------------------------------------------------------
// five-bit prefixes, bits 11:7, and whole codes
// ----------------------------------------------------------------
`define SMCC_TOP_POWER_STATE_CONTROLLER     5'h02
`define SMCC_TOP_PSTATE   5'h03
`define SMCC_TOP_EXTP     5'h04
`define SMCC_TOP_CSTATE   5'h05
`define SMCC_CODE_INTPEND 12'h0e0
`define SMCC_CODE_VEND_LO 12'h0e2
`define SMCC_CODE_VEND_HI 12'h0ff

`endif

/* File: rtl/smcc_pkg.sv */
// types shared by the management command codec files
package smcc_pkg;
  typedef enum logic [4:0] {
    KIND_RSVD     = 5'h00,
    KIND_LEG_IN   = 5'h01,
    KIND_LEG_OUT  = 5'h02,
    KIND_CLOCK_STOP_REQUEST   = 5'h03,
    KIND_CATASTROPHIC_ERROR_CYCLE = 5'h04,
    KIND_HALT     = 5'h05,
    KIND_STOPGNT  = 5'h06,
    KIND_VIDFID   = 5'h07,
    KIND_CACHE_WRITEBACK_INVALIDATE   = 5'h08,
    KIND_CACHE_INVALIDATE_ONLY     = 5'h09,
    KIND_MGMT_MODE_ACKNOWLEDGE   = 5'h0a,
    KIND_LEGACY_IRQ_LINE_MESSAGE     = 5'h0b,
    KIND_THROTTLE = 5'h0c,
    KIND_THERMAL  = 5'h0d,
    KIND_INTPEND  = 5'h0e,
    KIND_VENDOR   = 5'h0f,
    KIND_POWER_STATE_CONTROLLER     = 5'h10,
    KIND_PSTATE   = 5'h11,
    KIND_EXTP     = 5'h12,
    KIND_CSTATE   = 5'h13
  } smcc_kind_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h1,
    TX_HOLD = 2'h2
  } smcc_tx_state_t;
endpackage

/* File: rtl/smcc_classify.sv */
// sorts a 12-bit management command code into its message kind
`timescale 1ns/1ps
`default_nettype none
`include "smcc_defines.svh"

module smcc_classify (
  input  wire logic [11:0]       i_cmd,
  output smcc_pkg::smcc_kind_t   o_kind
);
  logic [7:0] grp;
  logic [4:0] top;

  assign grp = i_cmd[`SMCC_GRP_MSB:`SMCC_GRP_LSB];
  assign top = i_cmd[`SMCC_TOP_MSB:`SMCC_TOP_LSB];

  always_comb begin
    o_kind = smcc_pkg::KIND_RSVD;
    if (top == `SMCC_TOP_POWER_STATE_CONTROLLER) begin
      o_kind = smcc_pkg::KIND_POWER_STATE_CONTROLLER;
    end else if (top == `SMCC_TOP_PSTATE) begin
      o_kind = smcc_pkg::KIND_PSTATE;
    end else if (top == `SMCC_TOP_EXTP) begin
      o_kind = smcc_pkg::KIND_EXTP;
    end else if (top == `SMCC_TOP_CSTATE) begin
      o_kind = smcc_pkg::KIND_CSTATE;
    end else begin
      case (grp)
        `SMCC_GRP_LEG_IN:   o_kind = smcc_pkg::KIND_LEG_IN;
        `SMCC_GRP_LEG_OUT:  o_kind = smcc_pkg::KIND_LEG_OUT;
        `SMCC_GRP_CLOCK_STOP_REQUEST:   o_kind = smcc_pkg::KIND_CLOCK_STOP_REQUEST;
        `SMCC_GRP_CATASTROPHIC_ERROR_CYCLE: o_kind = smcc_pkg::KIND_CATASTROPHIC_ERROR_CYCLE;
        `SMCC_GRP_HALT:     o_kind = smcc_pkg::KIND_HALT;
        `SMCC_GRP_STOPGNT:  o_kind = smcc_pkg::KIND_STOPGNT;
        `SMCC_GRP_VIDFID:   o_kind = smcc_pkg::KIND_VIDFID;
        `SMCC_GRP_CACHE_WRITEBACK_INVALIDATE:   o_kind = smcc_pkg::KIND_CACHE_WRITEBACK_INVALIDATE;
        `SMCC_GRP_CACHE_INVALIDATE_ONLY:     o_kind = smcc_pkg::KIND_CACHE_INVALIDATE_ONLY;
        `SMCC_GRP_MGMT_MODE_ACKNOWLEDGE:   o_kind = smcc_pkg::KIND_MGMT_MODE_ACKNOWLEDGE;
        `SMCC_GRP_LEGACY_IRQ_LINE_MESSAGE:     o_kind = smcc_pkg::KIND_LEGACY_IRQ_LINE_MESSAGE;
        `SMCC_GRP_THROTTLE: o_kind = smcc_pkg::KIND_THROTTLE;
        // clear low bit is a reserved code
        `SMCC_GRP_THERMAL: begin
          if (i_cmd[`SMCC_WIRE_BIT]) begin
            o_kind = smcc_pkg::KIND_THERMAL;
          end
        end
        `SMCC_GRP_VW_LO, `SMCC_GRP_VW_HI: begin
          if (i_cmd == `SMCC_CODE_INTPEND) begin
            o_kind = smcc_pkg::KIND_INTPEND;
          end else if (i_cmd >= `SMCC_CODE_VEND_LO) begin
            o_kind = smcc_pkg::KIND_VENDOR;
          end
        end
        default: o_kind = smcc_pkg::KIND_RSVD;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: rtl/smcc_host.sv */
// host-side encoder and decoder of management command codes
`timescale 1ns/1ps
`default_nettype none
`include "smcc_defines.svh"

// Functional notes
// - one 12-bit code layout both directions
// - upper eight bits zero is reserved
// - group 01: numeric ignore bit0, a20 bit1
// - group 02: float error bit0, rest reserved
// - group 03: clock stop bit0, action 3:1
// - group 04: catastrophic_error_cycle, low bits implementation-specific
// - group 05: halt, bit3 exit flag
// - group 06: stop grant, action 3:1
// - group 07: voltage/frequency change, opaque low bits
// - groups 08/09: cache flush cycles, opaque bits
// - group 0a: management mode acknowledge bit0
// - group 0b: irq line select, level bit1
// - keep irq asserts and deasserts balanced
// - group 0c: throttling active flag bit0
// - group 0d bit0 set: thermal trip
// - 0e0 pending, 0e1 reserved, vendor above
// - prefix 00010 routes to power controller
// - core performance change, downstream only
// - extended performance change, same field layout
// - programmable core and state counts
// - prefix 00101 core idle change; 300+ reserved
// - wire bit one means asserted
module smcc_host (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // downstream requests from host logic
  input  wire logic        i_tx_valid,
  input  wire logic [4:0]  i_tx_kind,
  input  wire logic [8:0]  i_tx_data,
  input  wire logic [4:0]  i_core_count,
  input  wire logic [3:0]  i_pstate_count,
  output logic             o_tx_ready,
  output logic             o_tx_refused,
  // downstream command toward the link
  output logic             o_tx_valid,
  output logic [11:0]      o_tx_cmd,
  input  wire logic        i_tx_accept,
  // upstream command from the link
  input  wire logic        i_rx_valid,
  input  wire logic [11:0] i_rx_cmd,
  // decoded upstream state
  output logic             o_numeric_error_ignore_wire,
  output logic             o_address_bit20_mask_wire,
  output logic             o_clock_stop_request,
  output logic [2:0]       o_power_action_code,
  output logic [3:0]       o_irq_level,
  output logic             o_rx_event,
  output logic [4:0]       o_rx_kind,
  output logic [8:0]       o_rx_payload,
  output logic             o_rx_drop,
  output logic             o_core_valid,
  output logic             o_core_idle,
  output logic [3:0]       o_core_num,
  output logic [2:0]       o_core_state
);

  // ----------------------------------------------------------------
  // downstream encoder
  // ----------------------------------------------------------------
  smcc_pkg::smcc_tx_state_t tx_state;
  smcc_pkg::smcc_kind_t     tx_kind;
  logic [11:0]              next_tx_cmd;
  logic                     next_tx_ok;
  logic [3:0]               tx_low;
  logic [6:0]               tx_core;
  logic                     tx_take;

  assign tx_kind = smcc_pkg::smcc_kind_t'(i_tx_kind);
  assign tx_low  = i_tx_data[`SMCC_LOW_MSB:0];
  assign tx_core = i_tx_data[`SMCC_CORE_MSB:0];
  assign tx_take = i_tx_valid && o_tx_ready;

  // per-core field check against the programmed counts
  function automatic logic core_fits(input logic [6:0] f,
                                     input logic [4:0] cores,
                                     input logic [3:0] states);
    logic [4:0] c;
    logic [3:0] s;
    c = {1'b0, f[`SMCC_CORE_MSB:`SMCC_CORE_LSB]};
    s = {1'b0, f[`SMCC_STATE_MSB:0]};
    core_fits = (c < cores) && (s < states);
  endfunction

  always_comb begin
    next_tx_cmd = {`SMCC_GRP_RSVD, 4'h0};
    next_tx_ok  = 1'b1;
    case (tx_kind)
      smcc_pkg::KIND_LEG_IN:
        next_tx_cmd = {`SMCC_GRP_LEG_IN, 2'h0, tx_low[1:0]};
      smcc_pkg::KIND_LEG_OUT:
        next_tx_cmd = {`SMCC_GRP_LEG_OUT, 3'h0, tx_low[0]};
      smcc_pkg::KIND_CLOCK_STOP_REQUEST:
        next_tx_cmd = {`SMCC_GRP_CLOCK_STOP_REQUEST, tx_low};
      smcc_pkg::KIND_CATASTROPHIC_ERROR_CYCLE:
        next_tx_cmd = {`SMCC_GRP_CATASTROPHIC_ERROR_CYCLE, tx_low};
      smcc_pkg::KIND_HALT:
        next_tx_cmd = {`SMCC_GRP_HALT, tx_low};
      smcc_pkg::KIND_STOPGNT:
        next_tx_cmd = {`SMCC_GRP_STOPGNT, tx_low[3:1], 1'b0};
      smcc_pkg::KIND_VIDFID:
        next_tx_cmd = {`SMCC_GRP_VIDFID, tx_low};
      smcc_pkg::KIND_CACHE_WRITEBACK_INVALIDATE:
        next_tx_cmd = {`SMCC_GRP_CACHE_WRITEBACK_INVALIDATE, tx_low};
      smcc_pkg::KIND_CACHE_INVALIDATE_ONLY:
        next_tx_cmd = {`SMCC_GRP_CACHE_INVALIDATE_ONLY, tx_low};
      smcc_pkg::KIND_MGMT_MODE_ACKNOWLEDGE:
        next_tx_cmd = {`SMCC_GRP_MGMT_MODE_ACKNOWLEDGE, tx_low};
      smcc_pkg::KIND_LEGACY_IRQ_LINE_MESSAGE:
        next_tx_cmd = {`SMCC_GRP_LEGACY_IRQ_LINE_MESSAGE, tx_low[3:1], 1'b0};
      smcc_pkg::KIND_THROTTLE:
        next_tx_cmd = {`SMCC_GRP_THROTTLE, tx_low};
      smcc_pkg::KIND_THERMAL:
        next_tx_cmd = {`SMCC_GRP_THERMAL, tx_low[3:1], 1'b1};
      smcc_pkg::KIND_INTPEND:
        next_tx_cmd = `SMCC_CODE_INTPEND;
      smcc_pkg::KIND_VENDOR: begin
        next_tx_cmd = {3'h0, i_tx_data};
        next_tx_ok  = ({3'h0, i_tx_data} >= `SMCC_CODE_VEND_LO)
                   && ({3'h0, i_tx_data} <= `SMCC_CODE_VEND_HI);
      end
      smcc_pkg::KIND_POWER_STATE_CONTROLLER:
        next_tx_cmd = {`SMCC_TOP_POWER_STATE_CONTROLLER, tx_core};
      smcc_pkg::KIND_PSTATE: begin
        next_tx_cmd = {`SMCC_TOP_PSTATE, tx_core};
        next_tx_ok  = core_fits(tx_core, i_core_count, i_pstate_count);
      end
      smcc_pkg::KIND_EXTP: begin
        next_tx_cmd = {`SMCC_TOP_EXTP, tx_core};
        next_tx_ok  = core_fits(tx_core, i_core_count, i_pstate_count);
      end
      smcc_pkg::KIND_CSTATE:
        next_tx_cmd = {`SMCC_TOP_CSTATE, tx_core};
      // reserved or unknown kinds are never sent
      default:
        next_tx_ok = 1'b0;
    endcase
  end

  // one command held until the link takes it; no queue behind it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state   <= smcc_pkg::TX_IDLE;
      o_tx_ready <= 1'b1;
      o_tx_valid <= 1'b0;
      o_tx_cmd   <= {`SMCC_GRP_RSVD, 4'h0};
    end else begin
      case (tx_state)
        smcc_pkg::TX_IDLE: begin
          if (tx_take && next_tx_ok) begin
            tx_state   <= smcc_pkg::TX_HOLD;
            o_tx_ready <= 1'b0;
            o_tx_valid <= 1'b1;
            o_tx_cmd   <= next_tx_cmd;
          end
        end
        smcc_pkg::TX_HOLD: begin
          if (i_tx_accept) begin
            tx_state   <= smcc_pkg::TX_IDLE;
            o_tx_ready <= 1'b1;
            o_tx_valid <= 1'b0;
          end
        end
        default: begin
          tx_state   <= smcc_pkg::TX_IDLE;
          o_tx_ready <= 1'b1;
          o_tx_valid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_refused <= 1'b0;
    end else begin
      o_tx_refused <= tx_take && !next_tx_ok;
    end
  end

  // ----------------------------------------------------------------
  // upstream decoder
  // ----------------------------------------------------------------
  smcc_pkg::smcc_kind_t rx_kind;
  logic                 rx_up_only_bad;
  logic                 rx_core_kind;

  smcc_classify u_classify (
    .i_cmd  (i_rx_cmd),
    .o_kind (rx_kind)
  );

  // core performance changes never travel upstream, so drop them
  assign rx_up_only_bad = (rx_kind == smcc_pkg::KIND_PSTATE);
  assign rx_core_kind   = (rx_kind == smcc_pkg::KIND_EXTP)
                       || (rx_kind == smcc_pkg::KIND_CSTATE);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_numeric_error_ignore_wire <= 1'b0;
      o_address_bit20_mask_wire   <= 1'b0;
    end else if (i_rx_valid && rx_kind == smcc_pkg::KIND_LEG_IN) begin
      o_numeric_error_ignore_wire <= i_rx_cmd[`SMCC_WIRE_BIT];
      o_address_bit20_mask_wire   <= i_rx_cmd[`SMCC_A20_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clock_stop_request <= 1'b0;
      o_power_action_code  <= 3'h0;
    end else if (i_rx_valid && rx_kind == smcc_pkg::KIND_CLOCK_STOP_REQUEST) begin
      o_clock_stop_request <= i_rx_cmd[`SMCC_WIRE_BIT];
      o_power_action_code  <= i_rx_cmd[`SMCC_ACT_MSB:`SMCC_ACT_LSB];
    end
  end

  // per-line assert counters; saturate so a sender imbalance cannot wrap
  genvar gl;
  generate
    for (gl = 0; gl < `SMCC_LINES; gl = gl + 1) begin : g_line
      logic [3:0] cnt;
      logic       hit;
      assign hit = i_rx_valid && (rx_kind == smcc_pkg::KIND_LEGACY_IRQ_LINE_MESSAGE)
                && (i_rx_cmd[`SMCC_LINE_MSB:`SMCC_LINE_LSB] == 2'(gl));
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cnt <= `SMCC_CNT_ZERO;
        end else if (hit && i_rx_cmd[`SMCC_LVL_BIT]) begin
          if (cnt != `SMCC_CNT_MAX) begin
            cnt <= cnt + `SMCC_CNT_ONE;
          end
        end else if (hit && cnt != `SMCC_CNT_ZERO) begin
          cnt <= cnt - `SMCC_CNT_ONE;
        end
      end
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_irq_level[gl] <= 1'b0;
        end else if (hit && i_rx_cmd[`SMCC_LVL_BIT]) begin
          o_irq_level[gl] <= 1'b1;
        end else if (hit) begin
          o_irq_level[gl] <= (cnt > `SMCC_CNT_ONE);
        end
      end
    end
  endgenerate

  // generic event report; reserved and refused codes only raise drop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_event   <= 1'b0;
      o_rx_drop    <= 1'b0;
      o_rx_kind    <= 5'h00;
      o_rx_payload <= 9'h000;
    end else begin
      o_rx_event <= 1'b0;
      o_rx_drop  <= 1'b0;
      if (i_rx_valid) begin
        if (rx_kind == smcc_pkg::KIND_RSVD || rx_up_only_bad) begin
          o_rx_drop <= 1'b1;
        end else begin
          o_rx_event   <= 1'b1;
          o_rx_kind    <= rx_kind;
          o_rx_payload <= i_rx_cmd[`SMCC_PAY_W-1:0];
        end
      end
    end
  end

  // core change fields, only for kinds that carry them
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_valid <= 1'b0;
      o_core_idle  <= 1'b0;
      o_core_num   <= 4'h0;
      o_core_state <= 3'h0;
    end else begin
      o_core_valid <= i_rx_valid && rx_core_kind;
      if (i_rx_valid && rx_core_kind) begin
        o_core_idle  <= (rx_kind == smcc_pkg::KIND_CSTATE);
        o_core_num   <= i_rx_cmd[`SMCC_CORE_MSB:`SMCC_CORE_LSB];
        o_core_state <= i_rx_cmd[`SMCC_STATE_MSB:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  no_rsvd_send_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_tx_valid |-> o_tx_cmd[`SMCC_GRP_MSB:`SMCC_GRP_LSB] != `SMCC_GRP_RSVD
      && o_tx_cmd != `SMCC_CODE_INTPEND + 12'h001
  ) else $error("reserved code sent");

  cmd_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_tx_valid && !i_tx_accept |=> o_tx_valid && $stable(o_tx_cmd)
  ) else $error("command changed before accept");

  take_answer_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    tx_take |=> (o_tx_valid ^ o_tx_refused) && (o_tx_ready == o_tx_refused)
  ) else $error("taken request gave no answer");

  legout_rsvd_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_tx_valid && o_tx_cmd[11:4] == `SMCC_GRP_LEG_OUT |-> o_tx_cmd[3:1] == 3'h0
  ) else $error("float error reserved bits set");

  grant_rsvd_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_tx_valid && o_tx_cmd[11:4] == `SMCC_GRP_STOPGNT |-> !o_tx_cmd[0]
  ) else $error("stop grant bit0 set");

  legacy_irq_line_message_rsvd_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_tx_valid && o_tx_cmd[11:4] == `SMCC_GRP_LEGACY_IRQ_LINE_MESSAGE |-> !o_tx_cmd[0]
  ) else $error("irq line bit0 set");

  thermal_bit_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_tx_valid && o_tx_cmd[11:4] == `SMCC_GRP_THERMAL |-> o_tx_cmd[0]
  ) else $error("thermal code with clear bit0");

  wire_track_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_rx_valid && i_rx_cmd[11:4] == `SMCC_GRP_LEG_IN
      |=> o_numeric_error_ignore_wire == $past(i_rx_cmd[0])
       && o_address_bit20_mask_wire == $past(i_rx_cmd[1])
  ) else $error("legacy input wires not updated");

  stop_track_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_rx_valid && i_rx_cmd[11:4] == `SMCC_GRP_CLOCK_STOP_REQUEST
      |=> o_clock_stop_request == $past(i_rx_cmd[0])
       && o_power_action_code == $past(i_rx_cmd[3:1])
  ) else $error("clock stop state not updated");

  rsvd_drop_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_rx_valid && (i_rx_cmd[11:4] == `SMCC_GRP_RSVD || i_rx_cmd[11:8] >= 4'h3)
      |=> o_rx_drop && !o_rx_event && !o_core_valid
  ) else $error("reserved code acted on");

  pstate_up_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_rx_valid && i_rx_cmd[11:7] == `SMCC_TOP_PSTATE |=> o_rx_drop
  ) else $error("upstream performance change accepted");

  power_state_controller_route_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_rx_valid && i_rx_cmd[11:7] == `SMCC_TOP_POWER_STATE_CONTROLLER
      |=> o_rx_event && o_rx_kind == smcc_pkg::KIND_POWER_STATE_CONTROLLER && !o_core_valid
  ) else $error("controller code misrouted");

  idle_fields_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_rx_valid && i_rx_cmd[11:7] == `SMCC_TOP_CSTATE
      |=> o_core_valid && o_core_idle && o_core_num == $past(i_rx_cmd[6:3])
  ) else $error("idle change fields wrong");

endmodule
`default_nettype wire

/* File: dv/smcc_link_model.sv */
// link-side partner model: takes downstream commands, sends upstream ones
`timescale 1ns/1ps
`default_nettype none

module smcc_link_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_tx_valid,
  input  wire logic [11:0] i_tx_cmd,
  input  wire logic [3:0]  i_stall,
  output logic             o_accept,
  output logic [11:0]      o_got_cmd,
  output logic [7:0]       o_got_n,
  output logic             o_rx_valid,
  output logic [11:0]      o_rx_cmd
);
  logic [3:0] wait_cnt;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_cmd   = 12'h000;
  end

  // ----------------------------------------------------------------
  // downstream side
  // ----------------------------------------------------------------
  // a stall lets the encoder hold its word for several cycles
  always @(negedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_accept <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (o_accept) begin
      o_accept <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (i_tx_valid && wait_cnt >= i_stall) begin
      o_accept <= 1'b1;
    end else if (i_tx_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_got_n   <= 8'h00;
      o_got_cmd <= 12'h000;
    end else if (o_accept && i_tx_valid) begin
      o_got_n   <= o_got_n + 8'h01;
      o_got_cmd <= i_tx_cmd;
    end
  end

  // ----------------------------------------------------------------
  // upstream side
  // ----------------------------------------------------------------
  // reserved bits are only nonzero where the caller asks for it
  task automatic send(input logic [11:0] cmd);
    @(negedge i_clk);
    o_rx_valid = 1'b1;
    o_rx_cmd   = cmd;
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    // no pull on the bus: show the inverse rather than a stale word
    o_rx_cmd   = ~cmd;
  endtask
endmodule

`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the host-side management command codec
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk = 1'b0, rst_n = 1'b0, tv = 1'b0, acc, rdy, refd, ov, ign, a20, stp, ev, drp, cv, idle;
  logic [4:0] tk, cores, rk_o;
  logic [8:0] td, pay;
  logic [3:0] pcnt, stall, irq, cnum;
  logic [11:0] cmd, got, rxc;
  logic [7:0] gn;
  logic [2:0] act, cst;
  logic rxv;
  int miscompares = 0, compares = 0;
  logic [4:0]  tkind[10] = '{5'h01, 5'h02, 5'h06, 5'h0b, 5'h0d, 5'h0f, 5'h11, 5'h12, 5'h13, 5'h10};
  logic [8:0]  tdat[10]  = '{9'h00f, 9'h00f, 9'h00f, 9'h00f, 9'h000, 9'h0e2, 9'h01b, 9'h01b, 9'h07f, 9'h055};
  logic [11:0] texp[10]  = '{12'h013, 12'h021, 12'h06e, 12'h0be, 12'h0d1, 12'h0e2, 12'h19b, 12'h21b, 12'h2ff, 12'h155};
  logic [11:0] rcode[13] = '{12'h021, 12'h04a, 12'h058, 12'h06e, 12'h075, 12'h083, 12'h093, 12'h0a1, 12'h0c1,
                             12'h0d3, 12'h0e0, 12'h0f0, 12'h155};
  logic [4:0]  rkind[13] = '{5'h02, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10};
  logic [11:0] dcode[5]  = '{12'h005, 12'h0d0, 12'h0e1, 12'h300, 12'h19b};

  initial forever #2.5 clk = ~clk;

  smcc_host dut (.i_clk(clk), .i_rst_n(rst_n), .i_tx_valid(tv), .i_tx_kind(tk), .i_tx_data(td),
    .i_core_count(cores), .i_pstate_count(pcnt), .o_tx_ready(rdy), .o_tx_refused(refd), .o_tx_valid(ov),
    .o_tx_cmd(cmd), .i_tx_accept(acc), .i_rx_valid(rxv), .i_rx_cmd(rxc), .o_numeric_error_ignore_wire(ign),
    .o_address_bit20_mask_wire(a20), .o_clock_stop_request(stp), .o_power_action_code(act), .o_irq_level(irq),
    .o_rx_event(ev), .o_rx_kind(rk_o), .o_rx_payload(pay), .o_rx_drop(drp), .o_core_valid(cv),
    .o_core_idle(idle), .o_core_num(cnum), .o_core_state(cst));

  smcc_link_model link (.i_clk(clk), .i_rst_n(rst_n), .i_tx_valid(ov), .i_tx_cmd(cmd), .i_stall(stall),
    .o_accept(acc), .o_got_cmd(got), .o_got_n(gn), .o_rx_valid(rxv), .o_rx_cmd(rxc));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] seen);
    compares++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  task automatic tx_one(input logic [4:0] kind, input logic [8:0] data, input logic [11:0] exp,
                        input logic refuse);
    logic [7:0] n0;
    int i;
    n0 = gn;
    @(negedge clk);
    tv = 1'b1;
    tk = kind;
    td = data;
    @(negedge clk);
    tv = 1'b0;
    chk("tx_refused", 12'(refuse), 12'(refd));
    if (refuse) begin
      chk("tx_ready", 12'h001, 12'(rdy));
      chk("tx_valid", 12'h000, 12'(ov));
    end else begin
      chk("tx_cmd", exp, cmd);
      chk("tx_ready", 12'h000, 12'(rdy));
      for (i = 0; i < 20 && gn == n0; i++) @(negedge clk);
      if (gn == n0) begin
        miscompares++;
        complete_run();
      end
      chk("link_cmd", exp, got);
      chk("tx_valid_after", 12'h000, 12'(ov));
      chk("tx_ready_after", 12'h001, 12'(rdy));
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_encode();
    for (int i = 0; i < 10; i++) begin
      stall = i[0] ? 4'h3 : 4'h0;
      tx_one(tkind[i], tdat[i], texp[i], 1'b0);
    end
  endtask

  task automatic sc_refuse();
    tx_one(5'h00, 9'h000, 12'h000, 1'b1);
    tx_one(5'h14, 9'h000, 12'h000, 1'b1);
    tx_one(5'h0f, 9'h0e1, 12'h000, 1'b1);
    tx_one(5'h11, 9'h020, 12'h000, 1'b1);
    tx_one(5'h12, 9'h004, 12'h000, 1'b1);
    tx_one(5'h02, 9'h001, 12'h021, 1'b0);
    cores = 5'h10;
    pcnt  = 4'h8;
    tx_one(5'h11, 9'h07f, 12'h1ff, 1'b0);
    cores = 5'h02;
    tx_one(5'h12, 9'h01b, 12'h000, 1'b1);
  endtask

  // mid-run reset must clear the held wires and line counts
  task automatic sc_reset();
    link.send(12'h0b2);
    chk("irq_level", 12'h001, 12'(irq));
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk("rst_ignore_wire", 12'h000, 12'(ign));
    chk("rst_stop_wire", 12'h000, 12'(stp));
    chk("rst_irq_level", 12'h000, 12'(irq));
    chk("rst_ready", 12'h001, 12'(rdy));
    rst_n = 1'b1;
    tx_one(5'h02, 9'h001, 12'h021, 1'b0);
  endtask

  task automatic sc_legacy();
    link.send(12'h013);
    chk("ignore_wire", 12'h001, 12'(ign));
    chk("a20_wire", 12'h001, 12'(a20));
    link.send(12'h032);
    chk("stop_wire", 12'h000, 12'(stp));
    chk("action", 12'h001, 12'(act));
    link.send(12'h037);
    chk("stop_wire", 12'h001, 12'(stp));
    chk("action", 12'h003, 12'(act));
    chk("rx_payload", 12'h037, 12'(pay));
    link.send(12'h0b6);
    chk("irq_level", 12'h002, 12'(irq));
    link.send(12'h0b4);
    chk("irq_level", 12'h000, 12'(irq));
  endtask

  task automatic sc_kinds();
    for (int i = 0; i < 13; i++) begin
      link.send(rcode[i]);
      chk("rx_event", 12'h001, 12'(ev));
      chk("rx_kind", 12'(rkind[i]), 12'(rk_o));
    end
    for (int i = 0; i < 5; i++) begin
      link.send(dcode[i]);
      chk("rx_drop", 12'h001, 12'(drp));
      chk("rx_event", 12'h000, 12'(ev));
    end
  endtask

  task automatic sc_core();
    link.send(12'h2ab);
    chk("core_valid", 12'h001, 12'(cv));
    chk("core_idle", 12'h001, 12'(idle));
    chk("core_num", 12'h005, 12'(cnum));
    chk("core_state", 12'h003, 12'(cst));
    link.send(12'h21b);
    chk("core_idle", 12'h000, 12'(idle));
    chk("core_num", 12'h003, 12'(cnum));
  endtask

  initial begin
    tk    = 5'h00;
    td    = 9'h000;
    cores = 5'h04;
    pcnt  = 4'h4;
    stall = 4'h0;
    repeat (5) @(negedge clk);
    chk("rst_ready", 12'h001, 12'(rdy));
    chk("rst_tx_cmd", 12'h000, cmd);
    rst_n = 1'b1;
    sc_encode();
    sc_refuse();
    sc_legacy();
    sc_reset();
    sc_kinds();
    sc_core();
    complete_run();
  end
endmodule

`default_nettype wire
